// ### logic/rtcs_ctrl.sv
// RTC control, soft reset and read-synchronisation registers on AXI4-Lite
//
// The implementer's own choice: the AXI4-Lite slave port.
module rtcs_ctrl
   import rtcs_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int DIV_W = 10
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rtc_source_clock,
   input wire logic [31:0] count_value,
   input wire logic count_write,
   output logic rtc_counter_clock,
   output logic counter_enabled,
   output logic [1:0] operating_mode,
   output logic [3:0] prescaler_sel,
   output logic clear_on_compare,
   output logic hour_format_select,
   output logic soft_reset_active,
   output logic sync_in_progress,
   output logic [31:0] count_synced
);
   logic tick;
   logic tick_r, tick_nxt;
   // Bus write channel state
   rtcs_bus_t wst_r, wst_nxt;
   logic aw_held_r, aw_held_nxt, w_held_r, w_held_nxt;
   logic [ADDR_W-1:0] awaddr_r, awaddr_nxt;
   logic [31:0] wdata_r, wdata_nxt;
   logic [3:0] wstrb_r, wstrb_nxt;
   logic awready_r, awready_nxt, wready_r, wready_nxt;
   logic bvalid_r, bvalid_nxt;
   logic [1:0] bresp_r, bresp_nxt;
   logic do_wr;
   logic [ADDR_W-1:0] wr_idx;
   // Bus read channel state
   rtcs_bus_t rst_r, rst_nxt;
   logic arready_r, arready_nxt, rvalid_r, rvalid_nxt;
   logic [31:0] rdata_r, rdata_nxt;
   logic [1:0] rresp_r, rresp_nxt;
   logic [ADDR_W-1:0] rd_idx;
   // Control state
   logic enable_r, enable_nxt, active_r, active_nxt;
   rtcs_mode_t mode_r, mode_nxt;
   logic [3:0] presc_r, presc_nxt;
   logic clr_r, clr_nxt, hour_r, hour_nxt;
   logic soft_reset_trigger_r, soft_reset_trigger_nxt, continuous_read_sync_r, continuous_read_sync_nxt;
   logic en_pend_r, en_pend_nxt, rd_pend_r, rd_pend_nxt;
   logic [31:0] snap_r, snap_nxt;
   logic [15:0] ctrl_rd, read_sync_trigger_rd;
   logic [7:0] stat_rd;

   rtcs_prescaler #(.DIV_W(DIV_W)) i_rtcs_prescaler (
      .aclk(aclk),
      .aresetn(aresetn),
      .src_clk(rtc_source_clock),
      .presc(presc_r),
      .tick(tick)
   );

   // Readback images with reserved bits zero
   always_comb
   begin
      ctrl_rd = RTCS_CTRL_RST;
      ctrl_rd[RTCS_PRESC_LSB +: 4] = presc_r;
      ctrl_rd[RTCS_CLR_BIT] = clr_r;
      ctrl_rd[RTCS_HOUR_BIT] = hour_r;
      ctrl_rd[RTCS_MODE_LSB +: 2] = mode_r;
      ctrl_rd[RTCS_ENABLE_BIT] = enable_r;
      ctrl_rd[RTCS_SOFT_RESET_TRIGGER_BIT] = soft_reset_trigger_r;
      read_sync_trigger_rd = 16'h0000;
      read_sync_trigger_rd[5:0] = RTCS_READ_ADDR;
      read_sync_trigger_rd[RTCS_CONTINUOUS_READ_SYNC_BIT] = continuous_read_sync_r;
      stat_rd = 8'h00;
      stat_rd[RTCS_BUSY_BIT] = en_pend_r | rd_pend_r | soft_reset_trigger_r;
   end

   // Write channel: take address and data in either order, then respond
   always_comb
   begin
      wst_nxt = wst_r;
      aw_held_nxt = aw_held_r;
      w_held_nxt = w_held_r;
      awaddr_nxt = awaddr_r;
      wdata_nxt = wdata_r;
      wstrb_nxt = wstrb_r;
      bvalid_nxt = bvalid_r;
      bresp_nxt = bresp_r;
      do_wr = 1'b0;
      wr_idx = awaddr_r >> RTCS_ADDR_SHIFT;
      if (s_axi_awvalid && awready_r)
      begin
         aw_held_nxt = 1'b1;
         awaddr_nxt = s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_r)
      begin
         w_held_nxt = 1'b1;
         wdata_nxt = s_axi_wdata;
         wstrb_nxt = s_axi_wstrb;
      end
      case (wst_r)
         RTCS_BUS_IDLE:
         begin
            if (aw_held_r && w_held_r)
            begin
               do_wr = 1'b1;
               aw_held_nxt = 1'b0;
               w_held_nxt = 1'b0;
               bvalid_nxt = 1'b1;
               bresp_nxt = (wr_idx == ADDR_W'(RTCS_CTRL_IDX) ||
                            wr_idx == ADDR_W'(RTCS_READ_SYNC_TRIGGER_IDX) ||
                            wr_idx == ADDR_W'(RTCS_STAT_IDX) ||
                            wr_idx == ADDR_W'(RTCS_SNAP_IDX)) ?
                           RTCS_RESP_OKAY : RTCS_RESP_SLVERR;
               wst_nxt = RTCS_BUS_RESP;
            end
         end
         RTCS_BUS_RESP:
         begin
            if (s_axi_bready)
            begin
               bvalid_nxt = 1'b0;
               wst_nxt = RTCS_BUS_IDLE;
            end
         end
         default:
         begin
            wst_nxt = RTCS_BUS_IDLE;
         end
      endcase
      awready_nxt = !aw_held_nxt;
      wready_nxt = !w_held_nxt;
   end

   // Register write channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         wst_r <= RTCS_BUS_IDLE;
         aw_held_r <= 1'b0;
         w_held_r <= 1'b0;
         awaddr_r <= '0;
         wdata_r <= '0;
         wstrb_r <= '0;
         awready_r <= 1'b0;
         wready_r <= 1'b0;
         bvalid_r <= 1'b0;
         bresp_r <= RTCS_RESP_OKAY;
      end
      else
      begin
         wst_r <= wst_nxt;
         aw_held_r <= aw_held_nxt;
         w_held_r <= w_held_nxt;
         awaddr_r <= awaddr_nxt;
         wdata_r <= wdata_nxt;
         wstrb_r <= wstrb_nxt;
         awready_r <= awready_nxt;
         wready_r <= wready_nxt;
         bvalid_r <= bvalid_nxt;
         bresp_r <= bresp_nxt;
      end
   end

   // Read channel: one word per request, answered the cycle after it is taken
   always_comb
   begin
      rst_nxt = rst_r;
      arready_nxt = arready_r;
      rvalid_nxt = rvalid_r;
      rdata_nxt = rdata_r;
      rresp_nxt = rresp_r;
      rd_idx = s_axi_araddr >> RTCS_ADDR_SHIFT;
      case (rst_r)
         RTCS_BUS_IDLE:
         begin
            arready_nxt = 1'b1;
            if (s_axi_arvalid && arready_r)
            begin
               arready_nxt = 1'b0;
               rvalid_nxt = 1'b1;
               rresp_nxt = RTCS_RESP_OKAY;
               rst_nxt = RTCS_BUS_RESP;
               if (rd_idx == ADDR_W'(RTCS_CTRL_IDX))
                  rdata_nxt = {16'h0000, ctrl_rd};
               else if (rd_idx == ADDR_W'(RTCS_READ_SYNC_TRIGGER_IDX))
                  rdata_nxt = {16'h0000, read_sync_trigger_rd};
               else if (rd_idx == ADDR_W'(RTCS_STAT_IDX))
                  rdata_nxt = {24'h000000, stat_rd};
               else if (rd_idx == ADDR_W'(RTCS_SNAP_IDX))
                  rdata_nxt = snap_r;
               else
               begin
                  rdata_nxt = 32'h0000_0000;
                  rresp_nxt = RTCS_RESP_SLVERR;
               end
            end
         end
         RTCS_BUS_RESP:
         begin
            arready_nxt = 1'b0;
            if (s_axi_rready)
            begin
               rvalid_nxt = 1'b0;
               arready_nxt = 1'b1;
               rst_nxt = RTCS_BUS_IDLE;
            end
         end
         default:
         begin
            rst_nxt = RTCS_BUS_IDLE;
         end
      endcase
   end

   // Register read channel
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rst_r <= RTCS_BUS_IDLE;
         arready_r <= 1'b0;
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= RTCS_RESP_OKAY;
      end
      else
      begin
         rst_r <= rst_nxt;
         arready_r <= arready_nxt;
         rvalid_r <= rvalid_nxt;
         rdata_r <= rdata_nxt;
         rresp_r <= rresp_nxt;
      end
   end

   // Control registers and completion of synchronised operations on ticks
   always_comb
   begin
      enable_nxt = enable_r;
      active_nxt = active_r;
      mode_nxt = mode_r;
      presc_nxt = presc_r;
      clr_nxt = clr_r;
      hour_nxt = hour_r;
      soft_reset_trigger_nxt = soft_reset_trigger_r;
      continuous_read_sync_nxt = continuous_read_sync_r;
      en_pend_nxt = en_pend_r;
      rd_pend_nxt = rd_pend_r;
      snap_nxt = snap_r;
      // Counter-domain completion; a same-cycle new request wins below
      if (tick)
      begin
         if (soft_reset_trigger_r)
            soft_reset_trigger_nxt = 1'b0;
         if (en_pend_r)
         begin
            active_nxt = enable_r;
            en_pend_nxt = 1'b0;
         end
         if (rd_pend_r || continuous_read_sync_r)
         begin
            snap_nxt = count_value;
            rd_pend_nxt = 1'b0;
         end
      end
      if (count_write)
         continuous_read_sync_nxt = 1'b0;
      if (do_wr && !soft_reset_trigger_r && wr_idx == ADDR_W'(RTCS_CTRL_IDX) && wstrb_r[0] &&
          wdata_r[RTCS_SOFT_RESET_TRIGGER_BIT])
      begin
         // Reset wins over everything else in the same write
         enable_nxt = 1'b0;
         active_nxt = 1'b0;
         mode_nxt = RTCS_MODE_CNT32;
         presc_nxt = RTCS_PRESC_RST;
         clr_nxt = 1'b0;
         hour_nxt = 1'b0;
         continuous_read_sync_nxt = 1'b0;
         en_pend_nxt = 1'b0;
         rd_pend_nxt = 1'b0;
         snap_nxt = RTCS_SNAP_RST;
         soft_reset_trigger_nxt = 1'b1;
      end
      else if (do_wr && !soft_reset_trigger_r && wr_idx == ADDR_W'(RTCS_CTRL_IDX))
      begin
         if (wstrb_r[0])
         begin
            enable_nxt = wdata_r[RTCS_ENABLE_BIT];
            // Only a real enable or disable needs the handshake
            if (wdata_r[RTCS_ENABLE_BIT] != enable_r)
               en_pend_nxt = 1'b1;
            // Reserved mode code clamps to calendar
            mode_nxt = (wdata_r[RTCS_MODE_LSB +: 2] == RTCS_MODE_RSVD) ? RTCS_MODE_CLOCK :
                       rtcs_mode_t'(wdata_r[RTCS_MODE_LSB +: 2]);
            if (!enable_r)
            begin
               clr_nxt = wdata_r[RTCS_CLR_BIT];
               hour_nxt = wdata_r[RTCS_HOUR_BIT];
            end
         end
         if (wstrb_r[1])
         begin
            // Reserved divide codes clamp to the largest
            presc_nxt = (wdata_r[RTCS_PRESC_LSB +: 4] > RTCS_PRESC_MAX) ? RTCS_PRESC_MAX :
                        wdata_r[RTCS_PRESC_LSB +: 4];
         end
      end
      else if (do_wr && !soft_reset_trigger_r && wr_idx == ADDR_W'(RTCS_READ_SYNC_TRIGGER_IDX) && wstrb_r[1])
      begin
         continuous_read_sync_nxt = wdata_r[RTCS_CONTINUOUS_READ_SYNC_BIT];
         if (wdata_r[RTCS_READ_SYNC_TRIGGER_BIT])
            rd_pend_nxt = 1'b1;
      end
      // Ticks pass only while the counter is, or is becoming, enabled
      tick_nxt = tick & active_nxt;
   end

   // Register control state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         enable_r <= 1'b0;
         active_r <= 1'b0;
         mode_r <= RTCS_MODE_CNT32;
         presc_r <= RTCS_PRESC_RST;
         clr_r <= 1'b0;
         hour_r <= 1'b0;
         soft_reset_trigger_r <= 1'b0;
         continuous_read_sync_r <= 1'b0;
         en_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         snap_r <= RTCS_SNAP_RST;
         tick_r <= 1'b0;
      end
      else
      begin
         enable_r <= enable_nxt;
         active_r <= active_nxt;
         mode_r <= mode_nxt;
         presc_r <= presc_nxt;
         clr_r <= clr_nxt;
         hour_r <= hour_nxt;
         soft_reset_trigger_r <= soft_reset_trigger_nxt;
         continuous_read_sync_r <= continuous_read_sync_nxt;
         en_pend_r <= en_pend_nxt;
         rd_pend_r <= rd_pend_nxt;
         snap_r <= snap_nxt;
         tick_r <= tick_nxt;
      end
   end

   // Output flops
   logic clr_eff_r, hour_eff_r, busy_r;
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         clr_eff_r <= 1'b0;
         hour_eff_r <= 1'b0;
         busy_r <= 1'b0;
      end
      else
      begin
         clr_eff_r <= clr_nxt && (mode_nxt != RTCS_MODE_CNT16);
         hour_eff_r <= hour_nxt && (mode_nxt == RTCS_MODE_CLOCK);
         busy_r <= en_pend_nxt | rd_pend_nxt | soft_reset_trigger_nxt;
      end
   end

   assign s_axi_awready = awready_r;
   assign s_axi_wready = wready_r;
   assign s_axi_bvalid = bvalid_r;
   assign s_axi_bresp = bresp_r;
   assign s_axi_arready = arready_r;
   assign s_axi_rvalid = rvalid_r;
   assign s_axi_rdata = rdata_r;
   assign s_axi_rresp = rresp_r;
   assign rtc_counter_clock = tick_r;
   assign counter_enabled = active_r;
   assign operating_mode = mode_r;
   assign prescaler_sel = presc_r;
   assign clear_on_compare = clr_eff_r;
   assign hour_format_select = hour_eff_r;
   assign soft_reset_active = soft_reset_trigger_r;
   assign sync_in_progress = busy_r;
   assign count_synced = snap_r;
endmodule

// ### logic/rtcs_pkg.sv
// Constants, register map and types for the RTC control and read-sync block
package rtcs_pkg;
   // Register indices as printed; byte address is four times the index
   localparam logic [7:0] RTCS_CTRL_IDX = 8'h00;
   localparam logic [7:0] RTCS_READ_SYNC_TRIGGER_IDX = 8'h02;
   localparam logic [7:0] RTCS_STAT_IDX = 8'h0a;
   localparam logic [7:0] RTCS_SNAP_IDX = 8'h10;
   localparam int RTCS_ADDR_SHIFT = 2;
   // Control register field positions
   localparam int RTCS_SOFT_RESET_TRIGGER_BIT = 0;
   localparam int RTCS_ENABLE_BIT = 1;
   localparam int RTCS_MODE_LSB = 2;
   localparam int RTCS_HOUR_BIT = 6;
   localparam int RTCS_CLR_BIT = 7;
   localparam int RTCS_PRESC_LSB = 8;
   // Read-request register field positions
   localparam int RTCS_READ_SYNC_TRIGGER_BIT = 15;
   localparam int RTCS_CONTINUOUS_READ_SYNC_BIT = 14;
   localparam logic [5:0] RTCS_READ_ADDR = 6'h10;
   // Status register field position
   localparam int RTCS_BUSY_BIT = 7;
   // Reset values
   localparam logic [15:0] RTCS_CTRL_RST = 16'h0000;
   localparam logic [15:0] RTCS_READ_SYNC_TRIGGER_RST = 16'h0010;
   localparam logic [3:0] RTCS_PRESC_RST = 4'h0;
   localparam logic [3:0] RTCS_PRESC_MAX = 4'ha;
   localparam logic [31:0] RTCS_SNAP_RST = 32'h0000_0000;
   // Bus responses
   localparam logic [1:0] RTCS_RESP_OKAY = 2'b00;
   localparam logic [1:0] RTCS_RESP_SLVERR = 2'b10;
   // Operating modes
   typedef enum logic [1:0] {
      RTCS_MODE_CNT32 = 2'h0,
      RTCS_MODE_CNT16 = 2'h1,
      RTCS_MODE_CLOCK = 2'h2,
      RTCS_MODE_RSVD = 2'h3
   } rtcs_mode_t;
   // Bus channel states
   typedef enum logic [1:0] {
      RTCS_BUS_IDLE = 2'b00,
      RTCS_BUS_RESP = 2'b01
   } rtcs_bus_t;
endpackage

// ### logic/rtcs_prescaler.sv
// Power-of-two divider turning source clock edges into counter clock ticks
module rtcs_prescaler
   import rtcs_pkg::*;
#(
   parameter int DIV_W = 10
)
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic src_clk,
   input wire logic [3:0] presc,
   output logic tick
);
   logic src_prev_r, src_prev_nxt;
   logic [DIV_W-1:0] cnt_r, cnt_nxt;
   logic tick_r, tick_nxt;
   logic [DIV_W-1:0] mask;

   // Count rising source edges, tick on every 2^presc-th one
   always_comb
   begin
      mask = DIV_W'((1 << presc) - 1);
      src_prev_nxt = src_clk;
      cnt_nxt = cnt_r;
      tick_nxt = 1'b0;
      if (src_clk && !src_prev_r)
      begin
         cnt_nxt = cnt_r + 1'b1;
         if ((cnt_r & mask) == mask)
         begin
            tick_nxt = 1'b1;
         end
      end
   end

   // Register divider state
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         src_prev_r <= 1'b0;
         cnt_r <= '0;
         tick_r <= 1'b0;
      end
      else
      begin
         src_prev_r <= src_prev_nxt;
         cnt_r <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;
endmodule

// ### verification/rtcs_ctrl_properties.sv
// Port-level assertions for the RTC control block
module rtcs_ctrl_properties
   import rtcs_pkg::*;
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [31:0] s_axi_rdata,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic rtc_counter_clock,
   input wire logic counter_enabled,
   input wire logic [1:0] operating_mode,
   input wire logic [3:0] prescaler_sel,
   input wire logic clear_on_compare,
   input wire logic hour_format_select,
   input wire logic soft_reset_active,
   input wire logic sync_in_progress
);
   // One domain, held off in reset
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // Stored codes stay legal
   property p_presc;
      prescaler_sel <= RTCS_PRESC_MAX;
   endproperty
   a_presc: assert property (p_presc) else $error("prescaler out of range");
   property p_mode;
      operating_mode != RTCS_MODE_RSVD;
   endproperty
   a_mode: assert property (p_mode) else $error("reserved mode stored");
   // Mode-qualified control bits
   property p_clr;
      clear_on_compare |-> operating_mode != RTCS_MODE_CNT16;
   endproperty
   a_clr: assert property (p_clr) else $error("match clear in 16-bit mode");
   property p_hour;
      hour_format_select |-> operating_mode == RTCS_MODE_CLOCK;
   endproperty
   a_hour: assert property (p_hour) else $error("hour format outside calendar");
   // Ticks only reach an enabled counter
   property p_tick;
      rtc_counter_clock |-> counter_enabled;
   endproperty
   a_tick: assert property (p_tick) else $error("tick while disabled");
   // Enable changes only under a busy handshake
   property p_en_sync;
      $changed(counter_enabled) |-> $past(sync_in_progress) || sync_in_progress;
   endproperty
   a_en_sync: assert property (p_en_sync) else $error("enable moved without busy");
   // Soft reset end leaves block idle and off
   property p_srst_end;
      $fell(soft_reset_active) |-> ##[0:2] !sync_in_progress && !counter_enabled;
   endproperty
   a_srst_end: assert property (p_srst_end) else $error("soft reset end not clean");
   // Read answer stands until taken
   property p_rstand;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_rstand: assert property (p_rstand) else $error("read answer dropped");
endmodule

bind rtcs_ctrl rtcs_ctrl_properties i_rtcs_ctrl_properties (.aclk(aclk), .aresetn(aresetn),
   .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .rtc_counter_clock(rtc_counter_clock), .counter_enabled(counter_enabled),
   .operating_mode(operating_mode), .prescaler_sel(prescaler_sel),
   .clear_on_compare(clear_on_compare), .hour_format_select(hour_format_select),
   .soft_reset_active(soft_reset_active), .sync_in_progress(sync_in_progress));

// ### verification/rtcs_ctrl_test.sv
// Self-checking bench for the RTC control and read-sync block
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; \
   $display("ERROR %s expected %h seen %h", nm, e, g); end end
module rtcs_ctrl_test
   import rtcs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_CTRL = 8'h00;
   localparam logic [7:0] A_READ_SYNC_TRIGGER = 8'h08;
   localparam logic [7:0] A_STAT = 8'h28;
   localparam logic [7:0] A_SNAP = 8'h40;
   logic aclk, aresetn, awv, awr, wv, wrdy, bv, br, arv, arr, rv, rr, src, cwr, tck;
   logic en, clr, hf, srst, busy, src_on;
   logic [7:0] awa, ara;
   logic [31:0] wd, rd, cv, snap;
   logic [3:0] ws, psel;
   logic [1:0] bresp, rresp, mode, last_bresp;
   logic [1:0] ph = 2'h0;
   int failures, n_checks;
   int cyc = 0;

   rtcs_ctrl #(.ADDR_W(8), .DIV_W(10)) i_rtcs_ctrl (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr), .s_axi_wdata(wd),
      .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(bresp),
      .s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rresp), .s_axi_rvalid(rv),
      .s_axi_rready(rr), .rtc_source_clock(src), .count_value(cv), .count_write(cwr),
      .rtc_counter_clock(tck), .counter_enabled(en), .operating_mode(mode),
      .prescaler_sel(psel), .clear_on_compare(clr), .hour_format_select(hf),
      .soft_reset_active(srst), .sync_in_progress(busy), .count_synced(snap));

   // Bus clock
   initial
   begin
      aclk = 1'b0;
      forever #12.5 aclk = ~aclk;
   end

   // Source clock at a quarter rate, cycle count and hang guard
   always @(posedge aclk)
   begin
      cyc <= cyc + 1;
      if (src_on)
         ph <= ph + 2'h1;
      src <= ph[1];
      if (cyc == 30000)
      begin
         failures++;
         summarize();
      end
   end

   task automatic summarize();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Write with both channels offered together
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
      logic aw_done, w_done;
      aw_done = 1'b0;
      w_done = 1'b0;
      awa <= a;
      wd <= d;
      ws <= s;
      awv <= 1'b1;
      wv <= 1'b1;
      while (!(aw_done && w_done))
      begin
         @(posedge aclk);
         if (awr && !aw_done)
            awv <= 1'b0;
         if (wrdy && !w_done)
            wv <= 1'b0;
         aw_done |= awr;
         w_done |= wrdy;
      end
      do @(posedge aclk); while (bv !== 1'b1);
      last_bresp = bresp;
   endtask

   // Read, taking the answer one cycle late
   task automatic rdr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] e);
      ara <= a;
      arv <= 1'b1;
      do @(posedge aclk); while (arr !== 1'b1);
      arv <= 1'b0;
      do @(posedge aclk); while (rv !== 1'b1);
      rr <= 1'b1;
      @(posedge aclk);
      d = rd;
      e = rresp;
      rr <= 1'b0;
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] d;
      logic [1:0] e;
      rdr(a, d, e);
      `CHK("rdata", exp, d)
   endtask

   // Poll status until busy drops, bounded; next sync access only after it
   task automatic wb();
      logic [31:0] d;
      logic [1:0] e;
      for (int k = 0; k < 60; k++)
      begin
         rdr(A_STAT, d, e);
         if (d[RTCS_BUSY_BIT] === 1'b0)
            break;
      end
      `CHK("busy wait", 1'b0, d[RTCS_BUSY_BIT])
   endtask

   // Stop the source clock and let any edge in flight pass
   task automatic hold_src();
      src_on <= 1'b0;
      repeat (4) @(posedge aclk);
   endtask

   task automatic tw(output int t);
      do @(posedge aclk); while (tck !== 1'b1);
      t = cyc;
   endtask

   task automatic t_reset();
      logic [31:0] d;
      logic [1:0] e;
      rc(A_CTRL, 32'h0);
      rc(A_READ_SYNC_TRIGGER, 32'h10);
      rc(A_STAT, 32'h0);
      rdr(8'h0c, d, e);
      `CHK("resp", RTCS_RESP_SLVERR, e)
      wr(A_STAT, 32'h0);
      `CHK("bresp", RTCS_RESP_OKAY, last_bresp)
      wr(8'h0c, 32'h0);
      `CHK("bresp", RTCS_RESP_SLVERR, last_bresp)
   endtask

   task automatic t_modes();
      logic [1:0] x;
      for (int m = 0; m < 4; m++)
      begin
         x = (m == 3) ? 2'h2 : 2'(m);
         wr(A_CTRL, 32'(m) << 2);
         rc(A_CTRL, {28'h0, x, 2'b00});
         `CHK("mode", x, mode)
         `CHK("busy", 1'b0, busy)
      end
   endtask

   task automatic t_presc();
      int t0, t1;
      logic [3:0] q;
      wr(A_CTRL, 32'h0004);
      for (int p = 0; p < 16; p++)
      begin
         q = (p > 10) ? 4'ha : 4'(p);
         wr(A_CTRL, 32'(p) << 8, 4'b0010);
         rc(A_CTRL, {20'h0, q, 8'h04});
         `CHK("psel", q, psel)
      end
      for (int p = 0; p < 3; p += 2)
      begin
         wr(A_CTRL, (32'(p) << 8) | 32'h2);
         wb();
         tw(t0);
         tw(t1);
         `CHK("tick gap", 4 << p, t1 - t0)
         wr(A_CTRL, 32'h0);
         wb();
      end
   endtask

   task automatic t_enable();
      hold_src();
      wr(A_CTRL, 32'h0002);
      rc(A_CTRL, 32'h0002);
      rc(A_STAT, 32'h80);
      `CHK("enabled", 1'b0, en)
      `CHK("busy", 1'b1, busy)
      src_on <= 1'b1;
      wb();
      rc(A_STAT, 32'h0);
      `CHK("enabled", 1'b1, en)
      wr(A_CTRL, 32'h00ca);
      rc(A_CTRL, 32'h000a);
      `CHK("clr", 1'b0, clr)
      `CHK("busy", 1'b0, busy)
      wr(A_CTRL, 32'h0008);
      wb();
      `CHK("enabled", 1'b0, en)
      for (int m = 0; m < 3; m++)
      begin
         wr(A_CTRL, 32'hc0 | (m << 2));
         `CHK("clr", m != 1, clr)
         `CHK("hour", m == 2, hf)
      end
   endtask

   task automatic t_soft_reset_trigger();
      wr(A_CTRL, 32'h0106);
      wb();
      `CHK("enabled", 1'b1, en)
      hold_src();
      wr(A_CTRL, 32'h0a0b);
      rc(A_CTRL, 32'h0001);
      rc(A_STAT, 32'h80);
      `CHK("srst", 1'b1, srst)
      `CHK("enabled", 1'b0, en)
      src_on <= 1'b1;
      wb();
      rc(A_CTRL, 32'h0);
      `CHK("srst", 1'b0, srst)
      `CHK("psel", 4'h0, psel)
   endtask

   task automatic t_rsync();
      hold_src();
      cv <= 32'h1234_5678;
      wr(A_READ_SYNC_TRIGGER, 32'h803f);
      rc(A_READ_SYNC_TRIGGER, 32'h10);
      rc(A_STAT, 32'h80);
      src_on <= 1'b1;
      wb();
      rc(A_SNAP, 32'h1234_5678);
      `CHK("synced", 32'h1234_5678, snap)
      wr(A_READ_SYNC_TRIGGER, 32'h4000);
      rc(A_READ_SYNC_TRIGGER, 32'h4010);
      cv <= 32'h0bad_cafe;
      repeat (16) @(posedge aclk);
      rc(A_SNAP, 32'h0bad_cafe);
      cwr <= 1'b1;
      @(posedge aclk);
      cwr <= 1'b0;
      rc(A_READ_SYNC_TRIGGER, 32'h10);
      wr(A_READ_SYNC_TRIGGER, 32'h4000);
      wr(A_READ_SYNC_TRIGGER, 32'h0);
      rc(A_READ_SYNC_TRIGGER, 32'h10);
      cv <= 32'h5555_aaaa;
      repeat (16) @(posedge aclk);
      `CHK("synced", 32'h0bad_cafe, snap)
   endtask

   // Reset, then the scenarios in turn
   initial
   begin
      aresetn = 1'b0;
      awv = 1'b0;
      wv = 1'b0;
      br = 1'b1;
      arv = 1'b0;
      rr = 1'b0;
      awa = 8'h0;
      ara = 8'h0;
      wd = 32'h0;
      ws = 4'h0;
      cv = 32'h0;
      cwr = 1'b0;
      src_on = 1'b1;
      failures = 0;
      n_checks = 0;
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_reset();
      t_modes();
      t_presc();
      t_enable();
      t_soft_reset_trigger();
      t_rsync();
      summarize();
   end
endmodule
